// File: common/vtam_pkg.sv
// constants for the valve travel alert monitor: register map, reset values, scaling
// travel and set point are signed 16-bit in 0.1 % units, pressure in 0.01 psi units
package vtam_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PCT_W = 16;
  localparam int CFG_WORDS = 18;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_HH_POINT = 5'h01;
  localparam logic [4:0] IDX_LL_POINT = 5'h02;
  localparam logic [4:0] IDX_HI_POINT = 5'h03;
  localparam logic [4:0] IDX_LO_POINT = 5'h04;
  localparam logic [4:0] IDX_HYST = 5'h05;
  localparam logic [4:0] IDX_TCUT_HI = 5'h06;
  localparam logic [4:0] IDX_TCUT_LO = 5'h07;
  localparam logic [4:0] IDX_PCUT_HI = 5'h08;
  localparam logic [4:0] IDX_PCUT_LO = 5'h09;
  localparam logic [4:0] IDX_CEILING = 5'h0a;
  localparam logic [4:0] IDX_FLOOR = 5'h0b;
  localparam logic [4:0] IDX_CYC_DB = 5'h0c;
  localparam logic [4:0] IDX_CYC_POINT = 5'h0d;
  localparam logic [4:0] IDX_ACC_DB = 5'h0e;
  localparam logic [4:0] IDX_ACC_POINT = 5'h0f;
  localparam logic [4:0] IDX_PDEV_POINT = 5'h10;
  localparam logic [4:0] IDX_PDEV_TIME = 5'h11;
  localparam logic [4:0] IDX_CYC_COUNT = 5'h12;
  localparam logic [4:0] IDX_ACCUM = 5'h13;
  localparam logic [4:0] IDX_STATUS = 5'h14;
  localparam logic [4:0] IDX_TTARGET = 5'h15;
  localparam logic [4:0] IDX_PTARGET = 5'h16;

  // enable bits in control and alert bits in status share positions
  localparam int BIT_HH = 0;
  localparam int BIT_LL = 1;
  localparam int BIT_HI = 2;
  localparam int BIT_LO = 3;
  localparam int BIT_CYC = 4;
  localparam int BIT_ACC = 5;
  localparam int BIT_PDEV = 6;
  localparam int ALERT_W = 7;

  // special percentages, calibration deviation point and reset deviation time
  localparam logic signed [PCT_W-1:0] PCT_FORCE_HI = 16'sh04ce;
  localparam logic signed [PCT_W-1:0] PCT_FORCE_LO = 16'shff1a;
  localparam logic signed [PCT_W-1:0] PCT_OFF_HI = 16'sh04e2;
  localparam logic signed [PCT_W-1:0] PCT_OFF_LO = 16'shff06;
  localparam logic [PCT_W-1:0] PDEV_POINT_CAL = 16'h00c8;
  localparam logic [PCT_W-1:0] PDEV_TIME_RESET = 16'h001e;

  localparam logic [DATA_W-1:0] CFG_RESET [0:CFG_WORDS-1] = '{
    32'h0000_0000, 32'h0000_03b6, 32'h0000_0032, 32'h0000_0384, 32'h0000_0064,
    32'h0000_000a, 32'h0000_04e2, 32'h0000_ff06, 32'h0000_04e2, 32'h0000_ff06,
    32'h0000_04e2, 32'h0000_ff06, 32'h0000_000a, 32'h000f_4240, 32'h0000_000a,
    32'h000f_4240, 32'h0000_00c8, 32'h0000_001e};

  // evaluation tick timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int TICKS_PER_SEC = 1_000_000 / TICK_PERIOD_US;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: logic/vtam_hyst_alert.sv
// one travel limit alert with set point and clearing deadband
// assumes value, point and deadband are stable between evaluation ticks
`timescale 1ns/1ps
module vtam_hyst_alert #(
  parameter bit HIGH_SIDE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // evaluation
  input wire logic tick,
  input wire logic enable,
  input wire logic signed [vtam_pkg::PCT_W-1:0] value,
  input wire logic signed [vtam_pkg::PCT_W-1:0] point,
  input wire logic signed [vtam_pkg::PCT_W-1:0] hysteresis,
  // result
  output logic alert
);
  import vtam_pkg::*;
  // widened so point +/- deadband cannot wrap
  logic signed [PCT_W+1:0] v;
  logic signed [PCT_W+1:0] clear_at;
  logic trip;
  logic release_ok;

  always_comb begin
    v = (PCT_W+2)'(value);
    if (HIGH_SIDE) begin
      clear_at = (PCT_W+2)'(point) - (PCT_W+2)'(hysteresis);
      trip = v > (PCT_W+2)'(point);
      release_ok = v <= clear_at;
    end else begin
      clear_at = (PCT_W+2)'(point) + (PCT_W+2)'(hysteresis);
      trip = v < (PCT_W+2)'(point);
      release_ok = v >= clear_at;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alert <= 1'b0;
    end else if (tick) begin
      if (!enable) begin
        alert <= 1'b0;
      end else if (trip) begin
        alert <= 1'b1;
      end else if (release_ok) begin
        alert <= 1'b0;
      end
    end
  end
endmodule

// File: logic/vtam_monitor.sv
// valve travel alert monitor: travel limit alerts, target cutoffs and limits,
// cycle counter, travel accumulator and pressure deviation alert, AXI4-Lite slave
// assumes sensor and set point words arrive asynchronously and change slowly
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module vtam_monitor #(
  parameter int TICK_CYCLES = vtam_pkg::TICK_CYCLES,
  parameter int TICKS_PER_SEC = vtam_pkg::TICKS_PER_SEC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // measurement and set point, asynchronous
  input wire logic signed [vtam_pkg::PCT_W-1:0] ranged_travel,
  input wire logic signed [vtam_pkg::PCT_W-1:0] set_point,
  input wire logic signed [vtam_pkg::PCT_W-1:0] pressure_demand,
  input wire logic signed [vtam_pkg::PCT_W-1:0] pressure_actual,
  input wire logic calibration_done,
  // shaped targets and alerts
  output logic signed [vtam_pkg::PCT_W-1:0] travel_target,
  output logic signed [vtam_pkg::PCT_W-1:0] pressure_target,
  output logic [vtam_pkg::ALERT_W-1:0] alerts,
  // axi4-lite write address
  input wire logic [vtam_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [vtam_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [vtam_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [vtam_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import vtam_pkg::*;

  function automatic logic signed [PCT_W+1:0] wide(input logic [DATA_W-1:0] w);
    wide = (PCT_W+2)'($signed(w[PCT_W-1:0]));
  endfunction

  function automatic logic [PCT_W+1:0] abs_diff(input logic signed [PCT_W+1:0] a,
                                                 input logic signed [PCT_W+1:0] b);
    logic signed [PCT_W+1:0] d;
    d = a - b;
    abs_diff = (d < 0) ? (PCT_W+2)'(-d) : (PCT_W+2)'(d);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] data,
                                              input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // input synchronisers; words change slowly relative to the clock
  logic signed [PCT_W-1:0] trav_s1, trav_s2, sp_s1, sp_s2;
  logic signed [PCT_W-1:0] pd_s1, pd_s2, pa_s1, pa_s2;
  logic cal_s1, cal_s2, cal_s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trav_s1 <= '0;
      trav_s2 <= '0;
      sp_s1 <= '0;
      sp_s2 <= '0;
      pd_s1 <= '0;
      pd_s2 <= '0;
      pa_s1 <= '0;
      pa_s2 <= '0;
      cal_s1 <= 1'b0;
      cal_s2 <= 1'b0;
      cal_s3 <= 1'b0;
    end else begin
      trav_s1 <= ranged_travel;
      trav_s2 <= trav_s1;
      sp_s1 <= set_point;
      sp_s2 <= sp_s1;
      pd_s1 <= pressure_demand;
      pd_s2 <= pd_s1;
      pa_s1 <= pressure_actual;
      pa_s2 <= pa_s1;
      cal_s1 <= calibration_done;
      cal_s2 <= cal_s1;
      cal_s3 <= cal_s2;
    end
  end

  logic cal_pulse;
  assign cal_pulse = cal_s2 && !cal_s3;

  // periodic evaluation tick
  logic [31:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // axi4-lite slave: address and data taken in either order
  logic aw_full, w_full;
  logic [4:0] aw_idx;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [DATA_W-1:0] cfg [0:CFG_WORDS-1];
  logic [DATA_W-1:0] cycle_count, accum;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full <= 1'b0;
      aw_idx <= '0;
    end else if (s_axi_awvalid && !aw_full) begin
      aw_full <= 1'b1;
      // out-of-map addresses become an index past the map, so no word is touched
      aw_idx <= s_axi_awaddr[7] ? 5'h1f : s_axi_awaddr[6:2];
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && !w_full) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_idx > IDX_PTARGET) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration words; calibration reloads the deviation point
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg[i] <= CFG_RESET[i];
      end
    end else begin
      if (do_write && aw_idx < 5'(CFG_WORDS)) begin
        cfg[aw_idx] <= merge(cfg[aw_idx], w_data, w_strb);
      end
      if (cal_pulse) begin
        cfg[IDX_PDEV_POINT] <= DATA_W'(PDEV_POINT_CAL);
      end
    end
  end

  logic wr_count, wr_accum;
  assign wr_count = do_write && aw_idx == IDX_CYC_COUNT;
  assign wr_accum = do_write && aw_idx == IDX_ACCUM;

  // target shaping
  logic signed [PCT_W+1:0] sp_w, tcut_hi, tcut_lo, pcut_hi, pcut_lo, ceiling, floor_v;
  logic ceil_on, floor_on;
  logic signed [PCT_W+1:0] next_ttarget, next_ptarget;

  always_comb begin
    sp_w = (PCT_W+2)'(sp_s2);
    tcut_hi = wide(cfg[IDX_TCUT_HI]);
    tcut_lo = wide(cfg[IDX_TCUT_LO]);
    pcut_hi = wide(cfg[IDX_PCUT_HI]);
    pcut_lo = wide(cfg[IDX_PCUT_LO]);
    ceiling = wide(cfg[IDX_CEILING]);
    floor_v = wide(cfg[IDX_FLOOR]);
    ceil_on = ceiling != (PCT_W+2)'(PCT_OFF_HI);
    floor_on = floor_v != (PCT_W+2)'(PCT_OFF_LO);
    next_ttarget = sp_w;
    if (!ceil_on && tcut_hi != (PCT_W+2)'(PCT_OFF_HI) && sp_w > tcut_hi) begin
      next_ttarget = (PCT_W+2)'(PCT_FORCE_HI);
    end else if (!floor_on && tcut_lo != (PCT_W+2)'(PCT_OFF_LO) && sp_w < tcut_lo) begin
      next_ttarget = (PCT_W+2)'(PCT_FORCE_LO);
    end
    if (ceil_on && next_ttarget > ceiling) begin
      next_ttarget = ceiling;
    end
    if (floor_on && next_ttarget < floor_v) begin
      next_ttarget = floor_v;
    end
    next_ptarget = sp_w;
    if (pcut_hi != (PCT_W+2)'(PCT_OFF_HI) && sp_w > pcut_hi) begin
      next_ptarget = (PCT_W+2)'(PCT_FORCE_HI);
    end else if (pcut_lo != (PCT_W+2)'(PCT_OFF_LO) && sp_w < pcut_lo) begin
      next_ptarget = (PCT_W+2)'(PCT_FORCE_LO);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      travel_target <= '0;
      pressure_target <= '0;
    end else if (tick) begin
      travel_target <= next_ttarget[PCT_W-1:0];
      pressure_target <= next_ptarget[PCT_W-1:0];
    end
  end

  // travel limit alerts
  localparam logic [3:0] HIGH_SIDES = 4'b0101;
  localparam logic [4:0] POINT_IDX [0:3] = '{IDX_HH_POINT, IDX_LL_POINT,
                                            IDX_HI_POINT, IDX_LO_POINT};
  for (genvar g = 0; g < 4; g++) begin : limit
    vtam_hyst_alert #(.HIGH_SIDE(HIGH_SIDES[g])) alert_i (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .enable(cfg[IDX_CTRL][g]),
      .value(trav_s2),
      .point(cfg[POINT_IDX[g]][PCT_W-1:0]),
      .hysteresis(cfg[IDX_HYST][PCT_W-1:0]),
      .alert(alerts[g])
    );
  end

  // cycle counter: reference follows travel once outside the deadband
  logic signed [PCT_W+1:0] trav_w, cyc_ref, acc_ref;
  logic cyc_dir_up;
  logic [PCT_W+1:0] cyc_move, acc_move;
  logic cyc_out, cyc_rev, acc_out;
  logic [DATA_W-1:0] cyc_base, acc_base;

  always_comb begin
    trav_w = (PCT_W+2)'(trav_s2);
    cyc_move = abs_diff(trav_w, cyc_ref);
    cyc_out = tick && cyc_move > (PCT_W+2)'(cfg[IDX_CYC_DB][PCT_W-1:0]);
    cyc_rev = cyc_out && ((trav_w > cyc_ref) != cyc_dir_up);
    acc_move = abs_diff(trav_w, acc_ref);
    acc_out = tick && acc_move > (PCT_W+2)'(cfg[IDX_ACC_DB][PCT_W-1:0]);
    cyc_base = wr_count ? merge(cycle_count, w_data, w_strb) : cycle_count;
    acc_base = wr_accum ? merge(accum, w_data, w_strb) : accum;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_ref <= '0;
      cyc_dir_up <= 1'b1;
      cycle_count <= '0;
    end else begin
      if (cyc_out) begin
        cyc_ref <= trav_w;
        cyc_dir_up <= trav_w > cyc_ref;
      end
      // a software write and a count in one cycle both take effect
      cycle_count <= cyc_base + (cyc_rev ? 32'h1 : 32'h0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ref <= '0;
      accum <= '0;
    end else begin
      if (acc_out) begin
        acc_ref <= trav_w;
      end
      accum <= acc_base + (acc_out ? DATA_W'(acc_move) : 32'h0);
    end
  end

  // usage alerts hold until the value is below the point or the enable bit is cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alerts[BIT_CYC] <= 1'b0;
      alerts[BIT_ACC] <= 1'b0;
    end else begin
      if (!cfg[IDX_CTRL][BIT_CYC]) begin
        alerts[BIT_CYC] <= 1'b0;
      end else if (cycle_count > cfg[IDX_CYC_POINT]) begin
        alerts[BIT_CYC] <= 1'b1;
      end else if (cycle_count < cfg[IDX_CYC_POINT]) begin
        alerts[BIT_CYC] <= 1'b0;
      end
      if (!cfg[IDX_CTRL][BIT_ACC]) begin
        alerts[BIT_ACC] <= 1'b0;
      end else if (accum > cfg[IDX_ACC_POINT]) begin
        alerts[BIT_ACC] <= 1'b1;
      end else if (accum < cfg[IDX_ACC_POINT]) begin
        alerts[BIT_ACC] <= 1'b0;
      end
    end
  end

  // pressure deviation timer in ticks; 32 bits covers any 16-bit time
  logic [PCT_W+1:0] p_dev;
  logic p_over, p_under;
  logic [31:0] dev_ticks, dev_limit;

  always_comb begin
    p_dev = abs_diff((PCT_W+2)'(pd_s2), (PCT_W+2)'(pa_s2));
    p_over = p_dev > (PCT_W+2)'(cfg[IDX_PDEV_POINT][PCT_W-1:0]);
    p_under = p_dev < (PCT_W+2)'(cfg[IDX_PDEV_POINT][PCT_W-1:0]);
    dev_limit = 32'(cfg[IDX_PDEV_TIME][PCT_W-1:0] * TICKS_PER_SEC);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_ticks <= '0;
      alerts[BIT_PDEV] <= 1'b0;
    end else if (tick) begin
      if (!p_over) begin
        dev_ticks <= '0;
      end else if (dev_ticks <= dev_limit) begin
        dev_ticks <= dev_ticks + 32'h1;
      end
      if (!cfg[IDX_CTRL][BIT_PDEV]) begin
        alerts[BIT_PDEV] <= 1'b0;
      end else if (p_over && dev_ticks >= dev_limit) begin
        alerts[BIT_PDEV] <= 1'b1;
      end else if (p_under) begin
        alerts[BIT_PDEV] <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr[6:2])
        IDX_CYC_COUNT: s_axi_rdata <= cycle_count;
        IDX_ACCUM: s_axi_rdata <= accum;
        IDX_STATUS: s_axi_rdata <= DATA_W'(alerts);
        IDX_TTARGET: s_axi_rdata <= DATA_W'(travel_target);
        IDX_PTARGET: s_axi_rdata <= DATA_W'(pressure_target);
        default: begin
          if (s_axi_araddr[6:2] < 5'(CFG_WORDS) && !s_axi_araddr[7]) begin
            s_axi_rdata <= cfg[s_axi_araddr[6:2]];
          end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: tb/vtam_sensor_model.sv
// travel sensor, pressure sensor and set point source for the monitor
// levels change just after a rising edge and hold; the monitor syncs them
`timescale 1ns/1ps
module vtam_sensor_model (
  // clock
  input wire logic clk,
  // measurement path
  output logic signed [vtam_pkg::PCT_W-1:0] ranged_travel,
  output logic signed [vtam_pkg::PCT_W-1:0] set_point,
  output logic signed [vtam_pkg::PCT_W-1:0] pressure_demand,
  output logic signed [vtam_pkg::PCT_W-1:0] pressure_actual,
  output logic calibration_done
);
  import vtam_pkg::*;
  initial begin
    ranged_travel = 16'sh01f4;
    set_point = 16'sh01f4;
    pressure_demand = 16'sh0000;
    pressure_actual = 16'sh0000;
    calibration_done = 1'b0;
  end
  // all levels move together so no half-updated state is ever sampled
  task automatic drive(input logic signed [PCT_W-1:0] tv, sp, pd, pa, input logic cal);
    @(posedge clk);
    ranged_travel <= tv;
    set_point <= sp;
    pressure_demand <= pd;
    pressure_actual <= pa;
    calibration_done <= cal;
  endtask
endmodule

// File: tb/vtam_monitor_assertions.sv
// checker on the monitor ports: bus handshakes, tick pacing, alert causes
// bound into every vtam_monitor; sees its ports only
`timescale 1ns/1ps
module vtam_checker #(
  parameter int TICK_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // outputs and pressure inputs
  input wire logic signed [vtam_pkg::PCT_W-1:0] travel_target,
  input wire logic signed [vtam_pkg::PCT_W-1:0] pressure_target,
  input wire logic [vtam_pkg::ALERT_W-1:0] alerts,
  input wire logic signed [vtam_pkg::PCT_W-1:0] pressure_demand,
  input wire logic signed [vtam_pkg::PCT_W-1:0] pressure_actual,
  // bus
  input wire logic [vtam_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vtam_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [vtam_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import vtam_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since targets last moved; saturates so long idle runs stay quiet
  wire logic [31:0] ev = {travel_target, pressure_target};
  logic [31:0] prev;
  logic [15:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
      cnt <= '0;
    end else begin
      prev <= ev;
      cnt <= (ev != prev) ? 16'h0000 : cnt + 16'(cnt != 16'hffff);
    end
  end
  sequence s_recent_wr;
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endsequence
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rd_err;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7]
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  property p_wr_err;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[7]
      |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  endproperty
  property p_tick_pace;
    ev != prev |-> cnt >= TICK_CYCLES - 1;
  endproperty
  property p_pdev_cause;
    $rose(alerts[BIT_PDEV]) |-> $past(pressure_demand, 4) != $past(pressure_actual, 4);
  endproperty
  property p_cyc_clear;
    $fell(alerts[BIT_CYC]) |-> s_recent_wr;
  endproperty
  property p_acc_clear;
    $fell(alerts[BIT_ACC]) |-> s_recent_wr;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
  a_wr_err: assert property (p_wr_err) else $error("bad write not refused");
  a_tick_pace: assert property (p_tick_pace) else $error("target off tick");
  a_pdev_cause: assert property (p_pdev_cause) else $error("deviation alert w/o cause");
  a_cyc_clear: assert property (p_cyc_clear) else $error("cycle alert fell alone");
  a_acc_clear: assert property (p_acc_clear) else $error("accum alert fell alone");
endmodule
bind vtam_monitor vtam_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// File: tb/valve_travel_alert_monitor_tb.sv
// self-checking bench for the monitor: registers, alerts, targets, history
// drives an AXI4-Lite master and the sensor model; short tick for speed
`timescale 1ns/1ps
module valve_travel_alert_monitor_tb;
  import vtam_pkg::*;
  localparam int TC = 8;
  localparam int SETTLE = 4 * TC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic signed [PCT_W-1:0] tv, sp, pd, pa, ttgt, ptgt;
  logic cal, awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp;
  logic [ALERT_W-1:0] alerts;
  int fails = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  vtam_sensor_model sens (.clk(clk), .ranged_travel(tv), .set_point(sp),
    .pressure_demand(pd), .pressure_actual(pa), .calibration_done(cal));
  vtam_monitor #(.TICK_CYCLES(TC), .TICKS_PER_SEC(2)) dut (.clk(clk), .rst(rst),
    .ranged_travel(tv), .set_point(sp), .pressure_demand(pd), .pressure_actual(pa),
    .calibration_done(cal), .travel_target(ttgt), .pressure_target(ptgt), .alerts(alerts),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] ba(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction
  // bready stands with the request; each valid drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", 32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(what, rdata, exp);
    chk("rresp", 32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  task automatic settle;
    repeat (SETTLE) @(posedge clk);
  endtask
  task automatic t_regs;
    for (int i = 0; i < CFG_WORDS; i++) rd_chk("cfg", ba(5'(i)), CFG_RESET[i], RESP_OKAY);
    rd_chk("unmapped", 8'h80, 32'h0, RESP_SLVERR);
    wr(8'h80, 32'h1, RESP_SLVERR);
    wr(ba(IDX_STATUS), 32'h7f, RESP_OKAY);
    rd_chk("status", ba(IDX_STATUS), 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_travel;
    logic signed [15:0] tr [9] = '{16'sh01f4, 16'sh03c0, 16'sh03b1, 16'sh03ac, 16'sh037a,
                                   16'sh0028, 16'sh003b, 16'sh003c, 16'sh006e};
    logic [3:0] ex [9] = '{4'h0, 4'h5, 4'h5, 4'h4, 4'h0, 4'ha, 4'ha, 4'h8, 4'h0};
    wr(ba(IDX_CTRL), 32'hf, RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      sens.drive(tr[i], 16'sh01f4, 16'sh0000, 16'sh0000, 1'b0);
      settle();
      chk("travel alerts", 32'(alerts[3:0]), 32'(ex[i]));
    end
    sens.drive(16'sh03c0, 16'sh01f4, 16'sh0000, 16'sh0000, 1'b0);
    wr(ba(IDX_CTRL), 32'h0, RESP_OKAY);
    settle();
    chk("disabled alerts", 32'(alerts[3:0]), 32'h0);
    $display("test travel done");
  endtask
  task automatic tgt(input logic signed [15:0] s, input logic signed [15:0] et, ep);
    sens.drive(16'sh01f4, s, 16'sh0000, 16'sh0000, 1'b0);
    settle();
    chk("travel target", 32'(ttgt), 32'(et));
    chk("pressure target", 32'(ptgt), 32'(ep));
  endtask
  task automatic t_targets;
    tgt(16'sh0258, 16'sh0258, 16'sh0258);
    wr(ba(IDX_TCUT_HI), 32'h3e3, RESP_OKAY);
    wr(ba(IDX_PCUT_HI), 32'h3e3, RESP_OKAY);
    wr(ba(IDX_TCUT_LO), 32'h5, RESP_OKAY);
    wr(ba(IDX_PCUT_LO), 32'h5, RESP_OKAY);
    tgt(16'sh03e8, PCT_FORCE_HI, PCT_FORCE_HI);
    tgt(16'sh0000, PCT_FORCE_LO, PCT_FORCE_LO);
    wr(ba(IDX_CEILING), 32'h320, RESP_OKAY);
    wr(ba(IDX_FLOOR), 32'h64, RESP_OKAY);
    tgt(16'sh03e8, 16'sh0320, PCT_FORCE_HI);
    tgt(16'sh0000, 16'sh0064, PCT_FORCE_LO);
    $display("test targets done");
  endtask
  task automatic t_history;
    logic signed [15:0] tr [4] = '{16'sh0258, 16'sh01f9, 16'sh01fe, 16'sh0258};
    wr(ba(IDX_CYC_POINT), 32'h1, RESP_OKAY);
    wr(ba(IDX_ACC_POINT), 32'hc8, RESP_OKAY);
    wr(ba(IDX_CYC_COUNT), 32'h0, RESP_OKAY);
    wr(ba(IDX_ACCUM), 32'h0, RESP_OKAY);
    wr(ba(IDX_CTRL), 32'h30, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      sens.drive(tr[i], 16'sh01f4, 16'sh0000, 16'sh0000, 1'b0);
      settle();
    end
    rd_chk("cycle count", ba(IDX_CYC_COUNT), 32'h3, RESP_OKAY);
    rd_chk("accumulator", ba(IDX_ACCUM), 32'h122, RESP_OKAY);
    chk("history alerts", 32'(alerts[5:4]), 32'h3);
    wr(ba(IDX_CYC_COUNT), 32'h0, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("cycle cleared", 32'(alerts[5:4]), 32'h2);
    wr(ba(IDX_ACCUM), 32'h0, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("accum cleared", 32'(alerts[5:4]), 32'h0);
    $display("test history done");
  endtask
  task automatic t_pdev;
    wr(ba(IDX_PDEV_TIME), 32'h2, RESP_OKAY);
    wr(ba(IDX_CTRL), 32'h40, RESP_OKAY);
    sens.drive(16'sh0258, 16'sh01f4, 16'sh03e8, 16'sh02bc, 1'b0);
    repeat (2 * TC) @(posedge clk);
    chk("deviation early", 32'(alerts[BIT_PDEV]), 32'h0);
    repeat (8 * TC) @(posedge clk);
    chk("deviation late", 32'(alerts[BIT_PDEV]), 32'h1);
    sens.drive(16'sh0258, 16'sh01f4, 16'sh03e8, 16'sh0352, 1'b0);
    settle();
    chk("deviation gone", 32'(alerts[BIT_PDEV]), 32'h0);
    sens.drive(16'sh0258, 16'sh01f4, 16'sh03e8, 16'sh02bc, 1'b0);
    repeat (2 * TC) @(posedge clk);
    chk("timer restarted", 32'(alerts[BIT_PDEV]), 32'h0);
    wr(ba(IDX_PDEV_POINT), 32'h1f4, RESP_OKAY);
    sens.drive(16'sh0258, 16'sh01f4, 16'sh0000, 16'sh0000, 1'b1);
    repeat (4) @(posedge clk);
    sens.drive(16'sh0258, 16'sh01f4, 16'sh0000, 16'sh0000, 1'b0);
    rd_chk("cal point", ba(IDX_PDEV_POINT), 32'(PDEV_POINT_CAL), RESP_OKAY);
    $display("test deviation done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_travel();
    t_targets();
    t_history();
    t_pdev();
    close_out();
  end
endmodule
